// *** hw/lbcb_cond.sv ***
/*
 Condition evaluator shared by branch and conditional move.
 Assumes flags come from the status word register of the same clock.
*/
`timescale 1ns/100ps
module lbcb_cond (
	input wire logic [3:0] cond,
	input wire logic [lbcb_pkg::PSW_W-1:0] program_status_word,
	output logic hold
);
	import lbcb_pkg::*;
	logic sx; // Sign xor overflow
	// ==========================================
	// Code to flag mapping
	always_comb begin
		sx = program_status_word[PSW_S] ^ program_status_word[PSW_OV];
		case (cond)
			CC_GE: hold = ~sx;
			CC_LT: hold = sx;
			CC_GT: hold = ~(sx | program_status_word[PSW_Z]);
			CC_LE: hold = sx | program_status_word[PSW_Z];
			CC_C: hold = program_status_word[PSW_CY];
			CC_NC: hold = ~program_status_word[PSW_CY];
			CC_H: hold = ~(program_status_word[PSW_CY] | program_status_word[PSW_Z]);
			CC_NH: hold = program_status_word[PSW_CY] | program_status_word[PSW_Z];
			CC_Z: hold = program_status_word[PSW_Z];
			CC_NZ: hold = ~program_status_word[PSW_Z];
			CC_N: hold = program_status_word[PSW_S];
			CC_P: hold = ~program_status_word[PSW_S];
			CC_V: hold = program_status_word[PSW_OV];
			CC_NV: hold = ~program_status_word[PSW_OV];
			CC_SA: hold = program_status_word[PSW_SAT];
			CC_T: hold = 1'b1;
			default: hold = 1'b1;
		endcase
	end
endmodule

// *** hw/lbcb_exec.sv ***
/*
 Execution slice for AND forms, conditional branch, byte swaps, table call,
 memory bit clear and conditional move, with an APB register window.
 Assumes register values arrive with the instruction and memory answers on
 the same clock by a one-cycle ack.
*/
// Function
// - Register AND into second operand, flags
// - Immediate AND zero-extended, same flags
// - Branch target is own address plus displacement
// - Branch tests flags, never changes them
// - Signed codes use sign xor overflow
// - Unsigned codes use carry and zero
// - Remaining codes: zero, sign, overflow, saturation, always
// - Halfword swap with lower-half carry and zero, sign from bit 31
// - Word swap reverses bytes, word flags
// - Call saves return address and status
// - Call loads table entry, jumps base plus entry
// - Interrupt may suspend call after memory cycle
// - Immediate bit clear at register plus displacement
// - Register bit clear, bit from operand
// - Bit clear sets zero from old bit
// - Register conditional move picks source or operand
// - Immediate conditional move picks immediate or operand
`timescale 1ns/100ps
module lbcb_exec (
	input wire logic clk,
	input wire logic rst,
	input wire logic clkEn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic issueValid,
	output logic issueReady,
	input wire logic [31:0] instrWord,
	input wire logic [31:0] instrPc,
	input wire logic [31:0] srcAVal,
	input wire logic [31:0] srcBVal,
	output logic wbValid,
	output logic [4:0] wbIndex,
	output logic [31:0] wbData,
	output logic pcValid,
	output logic [31:0] nextPc,
	output logic memReq,
	output logic memWrite,
	output logic memByte,
	output logic [31:0] memAddr,
	output logic [15:0] memWdata,
	input wire logic memAck,
	input wire logic [15:0] memRdata,
	input wire logic irqPend,
	input wire logic irqResume,
	output logic suspended
);
	import lbcb_pkg::*;
	// ==========================================
	// State
	lbcb_state_e state_q, state_d; // Sequencer
	logic [PSW_W-1:0] psw_q, psw_d; // Status word
	logic [31:0] call_table_base_pointer_q, call_table_base_pointer_d; // Table base
	logic [31:0] call_table_return_pc_q, call_table_return_pc_d; // Saved return address
	logic [PSW_W-1:0] call_table_saved_status_q, call_table_saved_status_d; // Saved status
	logic [2:0] bitSel_q, bitSel_d; // Bit to clear
	logic [15:0] entry_q, entry_d; // Loaded table entry
	logic issueReady_q, issueReady_d;
	logic suspended_q, suspended_d; // Call parked by an interrupt
	logic wbValid_q, wbValid_d;
	logic [4:0] wbIndex_q, wbIndex_d;
	logic [31:0] wbData_q, wbData_d;
	logic pcValid_q, pcValid_d;
	logic [31:0] nextPc_q, nextPc_d;
	logic memReq_q, memReq_d;
	logic memWrite_q, memWrite_d;
	logic memByte_q, memByte_d;
	logic [31:0] memAddr_q, memAddr_d;
	logic [15:0] memWdata_q, memWdata_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	// ==========================================
	// Decode
	logic [15:0] lo, hi; // Instruction halfwords
	logic accept; // Instruction taken this edge
	logic isAnd, isAndi, isBcond, isCallt, isClrI, isClrR;
	logic isExt, isBsh, isBsw, isCmovR, isCmovI;
	logic [3:0] condSel; // Condition field in use
	logic condHold; // Condition result
	logic [31:0] swapRes; // Byte swap result
	logic swapCy, swapZ, swapS;
	logic [31:0] andRes; // AND result
	logic [7:0] oldByte; // Byte read for bit clear
	logic apbAcc, apbWr; // Access phase, write commit

	assign lo = instrWord[15:0];
	assign hi = instrWord[31:16];
	assign accept = issueValid & issueReady_q;
	assign isAnd = (lo[10:5] == OP_AND);
	assign isAndi = (lo[10:5] == OP_AND_WITH_IMMEDIATE);
	assign isBcond = (lo[10:7] == OP_BCOND);
	assign isCallt = (lo[15:6] == OP_TABLE_LOOKUP_CALL);
	assign isClrI = (lo[15:14] == OP_CLRI_TOP) && (lo[10:5] == OP_CLRI);
	assign isExt = (lo[10:5] == OP_EXT);
	assign isClrR = isExt && (hi == EXT_CLRR);
	assign isBsh = isExt && (lo[4:0] == 5'h00) && (hi[10:0] == EXT_BSH);
	assign isBsw = isExt && (lo[4:0] == 5'h00) && (hi[10:0] == EXT_BSW);
	assign isCmovR = isExt && (hi[10:5] == EXT_CMOVR) && !hi[0];
	assign isCmovI = isExt && (hi[10:5] == EXT_CMOVI) && !hi[0];
	// One evaluator for both users
	assign condSel = isBcond ? lo[3:0] : hi[4:1];
	assign andRes = isAndi ? (srcAVal & {16'h0000, hi}) : (srcBVal & srcAVal);
	assign oldByte = memRdata[7:0];
	assign apbAcc = psel & penable;
	assign apbWr = apbAcc & pready_q & pwrite;

	lbcb_cond uCond (
		.cond(condSel),
		.program_status_word(psw_q),
		.hold(condHold)
	);

	lbcb_swap uSwap (
		.src(srcBVal),
		.wordMode(isBsw),
		.result(swapRes),
		.carry(swapCy),
		.zero(swapZ),
		.sign(swapS)
	);
	// ==========================================
	// Next state
	always_comb begin
		state_d = state_q;
		psw_d = psw_q;
		call_table_base_pointer_d = call_table_base_pointer_q;
		call_table_return_pc_d = call_table_return_pc_q;
		call_table_saved_status_d = call_table_saved_status_q;
		bitSel_d = bitSel_q;
		entry_d = entry_q;
		wbValid_d = 1'b0;
		wbIndex_d = wbIndex_q;
		wbData_d = wbData_q;
		pcValid_d = 1'b0;
		nextPc_d = nextPc_q;
		memReq_d = memReq_q;
		memWrite_d = memWrite_q;
		memByte_d = memByte_q;
		memAddr_d = memAddr_q;
		memWdata_d = memWdata_q;
		// Register window writes, instructions override below
		if (apbWr) begin
			case (paddr)
				ADDR_PSW: psw_d = pwdata[PSW_W-1:0];
				ADDR_CALL_TABLE_BASE_POINTER: call_table_base_pointer_d = pwdata;
				ADDR_CALL_TABLE_RETURN_PC: call_table_return_pc_d = pwdata;
				ADDR_CALL_TABLE_SAVED_STATUS: call_table_saved_status_d = pwdata[PSW_W-1:0];
				default: ;
			endcase
		end
		case (state_q)
			ST_IDLE: begin
				if (accept) begin
					if (isAnd || isAndi) begin
						wbValid_d = 1'b1;
						wbIndex_d = lo[15:11];
						wbData_d = andRes;
						psw_d[PSW_OV] = 1'b0;
						psw_d[PSW_S] = andRes[31];
						psw_d[PSW_Z] = (andRes == WORD_RST);
					end else if (isBcond) begin
						pcValid_d = 1'b1;
						if (condHold) begin
							nextPc_d = instrPc + {{23{lo[15]}}, lo[15:11], lo[6:4], 1'b0};
						end else begin
							nextPc_d = instrPc + RET_STEP;
						end
					end else if (isCallt) begin
						call_table_return_pc_d = instrPc + RET_STEP;
						call_table_saved_status_d = psw_q;
						memReq_d = 1'b1;
						memWrite_d = 1'b0;
						memByte_d = 1'b0;
						memAddr_d = call_table_base_pointer_q + {25'h0000000, lo[5:0], 1'b0};
						state_d = ST_CTLOAD;
					end else if (isClrI || isClrR) begin
						memReq_d = 1'b1;
						memWrite_d = 1'b0;
						memByte_d = 1'b1;
						if (isClrI) begin
							memAddr_d = srcAVal + {{16{hi[15]}}, hi};
							bitSel_d = lo[13:11];
						end else begin
							memAddr_d = srcAVal;
							bitSel_d = srcBVal[2:0];
						end
						state_d = ST_BCREAD;
					end else if (isBsh || isBsw) begin
						wbValid_d = 1'b1;
						wbIndex_d = hi[15:11];
						wbData_d = swapRes;
						psw_d[PSW_CY] = swapCy;
						psw_d[PSW_OV] = 1'b0;
						psw_d[PSW_S] = swapS;
						psw_d[PSW_Z] = swapZ;
					end else if (isCmovR || isCmovI) begin
						wbValid_d = 1'b1;
						wbIndex_d = hi[15:11];
						if (!condHold) begin
							wbData_d = srcBVal;
						end else if (isCmovR) begin
							wbData_d = srcAVal;
						end else begin
							wbData_d = {{27{lo[4]}}, lo[4:0]};
						end
					end
				end
			end
			ST_CTLOAD: begin
				// Table entry read; a pending interrupt parks after it
				if (memAck) begin
					memReq_d = 1'b0;
					entry_d = memRdata;
					if (irqPend) begin
						state_d = ST_CTSUSP;
					end else begin
						pcValid_d = 1'b1;
						nextPc_d = call_table_base_pointer_q + {16'h0000, memRdata};
						state_d = ST_IDLE;
					end
				end
			end
			ST_CTSUSP: begin
				// Resume the jump once the interrupt returns
				if (irqResume) begin
					pcValid_d = 1'b1;
					nextPc_d = call_table_base_pointer_q + {16'h0000, entry_q};
					state_d = ST_IDLE;
				end
			end
			ST_BCREAD: begin
				// Read byte, clear the bit, schedule the write back
				if (memAck) begin
					psw_d[PSW_Z] = ~oldByte[bitSel_q];
					memWrite_d = 1'b1;
					memWdata_d = {8'h00, oldByte & ~(8'h01 << bitSel_q)};
					state_d = ST_BCWRITE;
				end
			end
			ST_BCWRITE: begin
				// Same address, hold until accepted
				if (memAck) begin
					memReq_d = 1'b0;
					memWrite_d = 1'b0;
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
		issueReady_d = (state_d == ST_IDLE);
		suspended_d = (state_d == ST_CTSUSP);
	end
	// ==========================================
	// APB answer, one wait cycle
	always_comb begin
		pready_d = apbAcc & ~pready_q;
		prdata_d = prdata_q;
		pslverr_d = 1'b0;
		if (pready_d) begin
			case (paddr)
				ADDR_PSW: prdata_d = {27'h0000000, psw_q};
				ADDR_CALL_TABLE_BASE_POINTER: prdata_d = call_table_base_pointer_q;
				ADDR_CALL_TABLE_RETURN_PC: prdata_d = call_table_return_pc_q;
				ADDR_CALL_TABLE_SAVED_STATUS: prdata_d = {27'h0000000, call_table_saved_status_q};
				ADDR_PC: prdata_d = nextPc_q;
				ADDR_STAT: prdata_d = {30'h00000000, suspended_q, ~issueReady_q};
				default: begin
					prdata_d = WORD_RST;
					pslverr_d = 1'b1;
				end
			endcase
		end
	end
	// ==========================================
	// Registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			psw_q <= PSW_RST;
			call_table_base_pointer_q <= WORD_RST;
			call_table_return_pc_q <= WORD_RST;
			call_table_saved_status_q <= PSW_RST;
			bitSel_q <= 3'h0;
			entry_q <= 16'h0000;
			issueReady_q <= 1'b0;
			suspended_q <= 1'b0;
			wbValid_q <= 1'b0;
			wbIndex_q <= 5'h00;
			wbData_q <= WORD_RST;
			pcValid_q <= 1'b0;
			nextPc_q <= WORD_RST;
			memReq_q <= 1'b0;
			memWrite_q <= 1'b0;
			memByte_q <= 1'b0;
			memAddr_q <= WORD_RST;
			memWdata_q <= 16'h0000;
			prdata_q <= WORD_RST;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else if (clkEn) begin
			state_q <= state_d;
			psw_q <= psw_d;
			call_table_base_pointer_q <= call_table_base_pointer_d;
			call_table_return_pc_q <= call_table_return_pc_d;
			call_table_saved_status_q <= call_table_saved_status_d;
			bitSel_q <= bitSel_d;
			entry_q <= entry_d;
			issueReady_q <= issueReady_d;
			suspended_q <= suspended_d;
			wbValid_q <= wbValid_d;
			wbIndex_q <= wbIndex_d;
			wbData_q <= wbData_d;
			pcValid_q <= pcValid_d;
			nextPc_q <= nextPc_d;
			memReq_q <= memReq_d;
			memWrite_q <= memWrite_d;
			memByte_q <= memByte_d;
			memAddr_q <= memAddr_d;
			memWdata_q <= memWdata_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end
	// Outputs straight from flops
	assign suspended = suspended_q;
	assign issueReady = issueReady_q;
	assign wbValid = wbValid_q;
	assign wbIndex = wbIndex_q;
	assign wbData = wbData_q;
	assign pcValid = pcValid_q;
	assign nextPc = nextPc_q;
	assign memReq = memReq_q;
	assign memWrite = memWrite_q;
	assign memByte = memByte_q;
	assign memAddr = memAddr_q;
	assign memWdata = memWdata_q;
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	// ==========================================
	// Checks
	logic idleAcc; // Accepted and clock enabled
	assign idleAcc = accept & clkEn & (state_q == ST_IDLE);
	andResult_a: assert property (@(posedge clk) disable iff (rst)
		idleAcc && isAnd |=> wbValid_q && wbData_q == $past(srcAVal & srcBVal)
		&& !psw_q[PSW_OV] && psw_q[PSW_Z] == (wbData_q == 32'h00000000))
		else $error("register AND result or flags wrong");
	andiZext_a: assert property (@(posedge clk) disable iff (rst)
		idleAcc && isAndi |=> wbData_q == ($past(srcAVal) & {16'h0000, $past(hi)})
		&& psw_q[PSW_S] == wbData_q[31])
		else $error("immediate AND result wrong");
	branchTaken_a: assert property (@(posedge clk) disable iff (rst)
		idleAcc && isBcond && condHold && lo[15:11] == 5'h00 && lo[6:4] == 3'h0
		|=> pcValid_q && nextPc_q == $past(instrPc))
		else $error("zero displacement branch not to itself");
	branchFlags_a: assert property (@(posedge clk) disable iff (rst)
		idleAcc && isBcond && !apbWr |=> psw_q == $past(psw_q)
		&& ($past(condHold) || nextPc_q == $past(instrPc) + 32'h00000002))
		else $error("branch changed flags or bad fall through");
	swapFlags_a: assert property (@(posedge clk) disable iff (rst)
		idleAcc && isBsh |=> wbData_q[15:0] == {$past(srcBVal[7:0]), $past(srcBVal[15:8])}
		&& psw_q[PSW_Z] == (wbData_q[15:0] == 16'h0000) && !psw_q[PSW_OV])
		else $error("halfword swap wrong");
	calltSave_a: assert property (@(posedge clk) disable iff (rst)
		idleAcc && isCallt |=> call_table_return_pc_q == $past(instrPc) + 32'h00000002
		&& call_table_saved_status_q == $past(psw_q) && memReq_q && memAddr_q[0] == 1'b0)
		else $error("call did not save return state");
	calltJump_a: assert property (@(posedge clk) disable iff (rst)
		clkEn && state_q == ST_CTLOAD && memAck && !irqPend
		|=> pcValid_q && nextPc_q == call_table_base_pointer_q + {16'h0000, $past(memRdata)})
		else $error("call target wrong");
	calltPark_a: assert property (@(posedge clk) disable iff (rst)
		clkEn && state_q == ST_CTLOAD && memAck && irqPend
		|=> suspended && !pcValid_q && !memReq_q)
		else $error("call not parked after memory cycle");
	bitClrZero_a: assert property (@(posedge clk) disable iff (rst)
		clkEn && state_q == ST_BCREAD && memAck |=> psw_q[PSW_Z] == !$past(oldByte[bitSel_q])
		&& memWrite_q && memWdata_q[bitSel_q] == 1'b0)
		else $error("bit clear zero flag or data wrong");
	apbWait_a: assert property (@(posedge clk) disable iff (rst)
		clkEn && apbAcc && !pready_q |=> pready_q ##1 !pready_q)
		else $error("APB ready not one cycle");
endmodule

// *** hw/lbcb_swap.sv ***
/*
 Byte swap datapath with its flag results.
 Assumes the caller picks halfword or word mode from the decoded opcode.
*/
`timescale 1ns/100ps
module lbcb_swap (
	input wire logic [31:0] src,
	input wire logic wordMode,
	output logic [31:0] result,
	output logic carry,
	output logic zero,
	output logic sign
);
	logic [3:0] byteZero; // Per byte zero test
	// ==========================================
	// Reorder bytes
	always_comb begin
		if (wordMode) begin
			result = {src[7:0], src[15:8], src[23:16], src[31:24]};
		end else begin
			result = {src[23:16], src[31:24], src[7:0], src[15:8]};
		end
	end
	// Zero test of each result byte
	genvar g;
	for (g = 0; g < 4; g++) begin : gByte
		assign byteZero[g] = (result[8*g +: 8] == 8'h00);
	end
	// ==========================================
	// Flags: carry and zero from lower half in halfword mode, whole word otherwise; sign from bit 31
	assign carry = wordMode ? (|byteZero) : (|byteZero[1:0]);
	assign zero = wordMode ? (&byteZero) : (&byteZero[1:0]);
	assign sign = result[31];
endmodule

// *** pkg/lbcb_pkg.sv ***
/*
 Constants, opcode fields and state type for the instruction execution slice.
 Assumes a 32-bit APB register window and a 16-bit data memory port.
*/
package lbcb_pkg;
	// ==========================================
	// Register window (byte addresses)
	localparam logic [7:0] ADDR_PSW = 8'h00; // Status word
	localparam logic [7:0] ADDR_CALL_TABLE_BASE_POINTER = 8'h04; // Table base pointer
	localparam logic [7:0] ADDR_CALL_TABLE_RETURN_PC = 8'h08; // Saved return address
	localparam logic [7:0] ADDR_CALL_TABLE_SAVED_STATUS = 8'h0C; // Saved status word
	localparam logic [7:0] ADDR_PC = 8'h10; // Last produced PC
	localparam logic [7:0] ADDR_STAT = 8'h14; // Busy and suspended
	// ==========================================
	// Status word bit positions
	localparam int PSW_Z = 0;
	localparam int PSW_S = 1;
	localparam int PSW_OV = 2;
	localparam int PSW_CY = 3;
	localparam int PSW_SAT = 4;
	localparam int PSW_W = 5;
	// ==========================================
	// Reset values
	localparam logic [4:0] PSW_RST = 5'h00;
	localparam logic [31:0] WORD_RST = 32'h00000000;
	// Return address step of the call
	localparam logic [31:0] RET_STEP = 32'h00000002;
	// ==========================================
	// Opcode fields
	localparam logic [5:0] OP_AND = 6'h0A; // Low bits 10:5
	localparam logic [5:0] OP_AND_WITH_IMMEDIATE = 6'h36; // Low bits 10:5
	localparam logic [3:0] OP_BCOND = 4'hB; // Low bits 10:7
	localparam logic [9:0] OP_TABLE_LOOKUP_CALL = 10'h008; // Low bits 15:6
	localparam logic [1:0] OP_CLRI_TOP = 2'h2; // Low bits 15:14
	localparam logic [5:0] OP_CLRI = 6'h3E; // Low bits 10:5
	localparam logic [5:0] OP_EXT = 6'h3F; // Low bits 10:5
	localparam logic [15:0] EXT_CLRR = 16'h00E4; // High halfword
	localparam logic [10:0] EXT_BSH = 11'h342; // High bits 10:0
	localparam logic [10:0] EXT_BSW = 11'h340; // High bits 10:0
	localparam logic [5:0] EXT_CMOVR = 6'h19; // High bits 10:5
	localparam logic [5:0] EXT_CMOVI = 6'h18; // High bits 10:5
	// ==========================================
	// Condition codes
	localparam logic [3:0] CC_V = 4'h0;
	localparam logic [3:0] CC_C = 4'h1;
	localparam logic [3:0] CC_Z = 4'h2;
	localparam logic [3:0] CC_NH = 4'h3;
	localparam logic [3:0] CC_N = 4'h4;
	localparam logic [3:0] CC_T = 4'h5;
	localparam logic [3:0] CC_LT = 4'h6;
	localparam logic [3:0] CC_LE = 4'h7;
	localparam logic [3:0] CC_NV = 4'h8;
	localparam logic [3:0] CC_NC = 4'h9;
	localparam logic [3:0] CC_NZ = 4'hA;
	localparam logic [3:0] CC_H = 4'hB;
	localparam logic [3:0] CC_P = 4'hC;
	localparam logic [3:0] CC_SA = 4'hD;
	localparam logic [3:0] CC_GE = 4'hE;
	localparam logic [3:0] CC_GT = 4'hF;
	// ==========================================
	// Sequencer states
	typedef enum logic [2:0] {ST_IDLE, ST_CTLOAD, ST_CTSUSP, ST_BCREAD, ST_BCWRITE} lbcb_state_e;
endpackage

// *** tb/lbcb_mem_model.sv ***
/*
 Byte-wide data memory that answers the execution slice's memory port.
 Assumes requests are held until acked; latency alternates 0 and 2 cycles.
*/
`timescale 1ns/100ps
module lbcb_mem_model (
	input wire logic clk,
	input wire logic memReq,
	input wire logic memWrite,
	input wire logic memByte,
	input wire logic [31:0] memAddr,
	input wire logic [15:0] memWdata,
	output logic memAck,
	output logic [15:0] memRdata
);
	logic [7:0] bytes [256]; // Low address bits only
	logic [31:0] lastAddr; // Address of the last access served
	int cnt = 0; // Idle cycles waited
	int lat = 0; // Latency of the next access
	initial memAck = 1'b0;
	initial memRdata = 16'h0000;
	// ==========================================
	// Serve one access after lat idle cycles
	always @(posedge clk) begin
		memAck <= 1'b0;
		memRdata <= ~memRdata; // Garbage between acks
		if (memReq && !memAck) begin
			if (cnt < lat) begin
				cnt <= cnt + 1;
			end else begin
				cnt <= 0;
				lat <= 2 - lat;
				memAck <= 1'b1;
				lastAddr <= memAddr;
				memRdata <= {bytes[memAddr[7:0] + 8'h01], bytes[memAddr[7:0]]};
				if (memWrite) begin
					bytes[memAddr[7:0]] <= memWdata[7:0];
				end
			end
		end
	end
endmodule

// *** tb/test_lbcb_exec.sv ***
/*
 Self-checking bench for the execution slice over APB and instruction issue.
 Assumes the memory model is compiled before this file.
*/
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin failures++; \
	$display("CHECK FAILED %s expected %h seen %h", n, e, a); end end
module test_lbcb_exec;
	logic clk = 1'b0, rst = 1'b1, clkEn = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic issueValid = 1'b0, issueReady, wbValid, pcValid, suspended;
	logic [31:0] instrWord = 32'h0, instrPc = 32'h0, srcAVal = 32'h0, srcBVal = 32'h0;
	logic [4:0] wbIndex;
	logic [31:0] wbData, nextPc, memAddr;
	logic memReq, memWrite, memByte, memAck, irqPend = 1'b0, irqResume = 1'b0;
	logic [15:0] memWdata, memRdata;
	int failures = 0, n_tests = 0, cycles = 0;
	always #5 clk = ~clk;
	lbcb_exec dut (.clk(clk), .rst(rst), .clkEn(clkEn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .issueValid(issueValid), .issueReady(issueReady),
		.instrWord(instrWord), .instrPc(instrPc), .srcAVal(srcAVal), .srcBVal(srcBVal),
		.wbValid(wbValid), .wbIndex(wbIndex), .wbData(wbData), .pcValid(pcValid),
		.nextPc(nextPc), .memReq(memReq), .memWrite(memWrite), .memByte(memByte),
		.memAddr(memAddr), .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata),
		.irqPend(irqPend), .irqResume(irqResume), .suspended(suspended));
	lbcb_mem_model mem (.clk(clk), .memReq(memReq), .memWrite(memWrite), .memByte(memByte),
		.memAddr(memAddr), .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata));
	// ==========================================
	// Verdict and end of run
	task automatic stop_test();
		if (failures == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			stop_test();
		end
	end
	// ==========================================
	// One APB transfer, held until pready
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	// Read and compare one register
	task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(n, e, rd)
	endtask
	// Offer one instruction; returns at the edge after acceptance
	task automatic iss(input logic [31:0] w, pc, a, b);
		issueValid <= 1'b1;
		instrWord <= w;
		instrPc <= pc;
		srcAVal <= a;
		srcBVal <= b;
		do @(posedge clk); while (issueReady !== 1'b1);
		issueValid <= 1'b0;
		@(posedge clk);
	endtask
	// Wait for a multi-cycle instruction to finish
	task automatic idle();
		while (issueReady !== 1'b1) @(posedge clk);
	endtask
	// Expected branch decision from code and flags
	function automatic logic cnd(input logic [3:0] c, input logic [4:0] f);
		logic b;
		case (c[2:0])
			3'h0: b = f[2];
			3'h1: b = f[3];
			3'h2: b = f[0];
			3'h3: b = f[3] | f[0];
			3'h4: b = f[1];
			3'h5: b = c[3] ? ~f[4] : 1'b1;
			3'h6: b = f[1] ^ f[2];
			default: b = (f[1] ^ f[2]) | f[0];
		endcase
		return b ^ c[3];
	endfunction
	// ==========================================
	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		rdchk("psw reset", 8'h00, 32'h0);
		rdchk("base reset", 8'h04, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		`CHK("unmapped", 1'b1, err)
		// Logic ops keep carry and saturation
		apb(1'b1, 8'h00, 32'h1C);
		iss({16'h0, 5'h03, 6'h0A, 5'h01}, 32'h100, 32'hF0F0FF00, 32'h8F0F0F00);
		`CHK("and wb", {1'b1, 5'h03, 32'h80000F00}, {wbValid, wbIndex, wbData})
		rdchk("and psw", 8'h00, 32'h1A);
		iss({16'h1234, 5'h04, 6'h36, 5'h02}, 32'h104, 32'hFFFF1200, 32'h5);
		`CHK("and_with_immediate wb", {1'b1, 5'h04, 32'h1200}, {wbValid, wbIndex, wbData})
		rdchk("and_with_immediate psw", 8'h00, 32'h18);
		// Byte swaps
		apb(1'b1, 8'h00, 32'h14);
		iss({5'h07, 11'h342, 5'h02, 6'h3F, 5'h00}, 32'h108, 32'h0, 32'h11000080);
		`CHK("bsh wb", {1'b1, 5'h07, 32'h00118000}, {wbValid, wbIndex, wbData})
		rdchk("bsh psw", 8'h00, 32'h18);
		apb(1'b1, 8'h00, 32'h14);
		iss({5'h08, 11'h340, 5'h02, 6'h3F, 5'h00}, 32'h10C, 32'h0, 32'h11000080);
		`CHK("bsw wb", {1'b1, 5'h08, 32'h80000011}, {wbValid, wbIndex, wbData})
		rdchk("bsw psw", 8'h00, 32'h1A);
		// Conditional moves, both forms, on the zero condition
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 8'h00, {31'h0, i[0]});
			iss({5'h09, 5'h0C, i[1], 5'h04, 5'h02, 6'h3F, 5'h1C}, 32'h110, 32'hAAAA0001, 32'h5555);
			`CHK("conditional_move wb", {1'b1, 5'h09, i[0] ? (i[1] ? 32'hAAAA0001 : 32'hFFFFFFFC) : 32'h5555}, {wbValid, wbIndex, wbData})
			rdchk("conditional_move psw", 8'h00, {31'h0, i[0]});
		end
		// Every condition code against every flag pattern
		for (int p = 0; p < 32; p++) begin
			apb(1'b1, 8'h00, 32'(p));
			for (int c = 0; c < 16; c++) begin
				iss({16'h0, 5'h1F, 4'hB, 3'h5, c[3:0]}, 32'h4000, 32'h0, 32'h0);
				`CHK("branch", {1'b1, cnd(c[3:0], p[4:0]) ? 32'h3FFA : 32'h4002}, {pcValid, nextPc})
			end
			rdchk("branch psw", 8'h00, 32'(p));
		end
		// Table call, plain then parked by an interrupt
		apb(1'b1, 8'h04, 32'h1000);
		apb(1'b1, 8'h00, 32'h0B);
		mem.bytes[8'h54] = 8'h34;
		mem.bytes[8'h55] = 8'h12;
		iss({16'h0, 10'h008, 6'h2A}, 32'h2000, 32'h0, 32'h0);
		idle();
		`CHK("call pc", {1'b1, 32'h2234}, {pcValid, nextPc})
		`CHK("call addr", 32'h1054, mem.lastAddr)
		rdchk("call ret", 8'h08, 32'h2002);
		rdchk("call save", 8'h0C, 32'h0B);
		rdchk("call psw", 8'h00, 32'h0B);
		irqPend <= 1'b1;
		iss({16'h0, 10'h008, 6'h2A}, 32'h3000, 32'h0, 32'h0);
		while (suspended !== 1'b1) @(posedge clk);
		irqPend <= 1'b0;
		irqResume <= 1'b1;
		@(posedge clk);
		irqResume <= 1'b0;
		@(posedge clk);
		`CHK("resume pc", {1'b1, 32'h2234}, {pcValid, nextPc})
		rdchk("resume ret", 8'h08, 32'h3002);
		// Memory bit clear, immediate then register form
		mem.bytes[8'hF0] = 8'h08;
		mem.bytes[8'hF1] = 8'h0F;
		apb(1'b1, 8'h00, 32'h1F);
		iss({16'hFFF0, 2'h2, 3'h3, 6'h3E, 5'h01}, 32'h5000, 32'h100, 32'h0);
		idle();
		`CHK("clr imm byte", 8'h00, mem.bytes[8'hF0])
		rdchk("clr imm psw", 8'h00, 32'h1E);
		iss({16'h00E4, 5'h02, 6'h3F, 5'h01}, 32'h5004, 32'hF1, 32'hFFFFFFF5);
		idle();
		`CHK("clr reg addr", 32'hF1, mem.lastAddr)
		`CHK("clr size", 1'b1, memByte)
		`CHK("clr reg byte", 8'h0F, mem.bytes[8'hF1])
		rdchk("clr reg psw", 8'h00, 32'h1F);
		stop_test();
	end
endmodule
